// [logic/xdl_core.sv]
// Purpose: decode and execute literal xor, file xor and direction load
// Assumes: one instruction offered per cycle, file read data arrives combinationally
// Notes: the direction registers live here and answer file-space accesses
`timescale 1ns/1ps
`default_nettype none
module xdl_core (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic instr_valid,
   input wire logic [13:0] instr_word,
   input wire logic [7:0] file_rdata,
   input wire logic file_we_ext,
   input wire logic [6:0] file_addr_ext,
   input wire logic [7:0] file_wdata_ext,
   output logic [6:0] file_addr,
   output logic file_we,
   output logic [7:0] file_wdata,
   output logic [7:0] dir_rdata,
   output logic dir_hit,
   output logic [7:0] acc,
   output logic zero_flag,
   output logic [23:0] dir_regs,
   output logic done
);
   typedef struct packed {
      logic [7:0] acc;
      logic zero;
      logic [2:0][7:0] dir;
      logic done;
      xdl_pkg::xdl_op_e last_op;
   } xdl_state_s;

   xdl_state_s r;
   xdl_state_s next_r;
   logic is_lit;
   logic is_file;
   logic is_dir;
   logic [7:0] lit_res;
   logic [7:0] file_res;
   logic [7:0] file_src;
   logic [1:0] dir_sel;
   logic dir_ok;
   logic ext_dir_hit;
   logic [1:0] ext_sel;

   // opcode decode and datapath
   always_comb begin
      is_lit = instr_valid && (instr_word[13:8] == xdl_pkg::op_xor_literal);
      is_file = instr_valid && (instr_word[13:8] == xdl_pkg::op_xor_file);
      is_dir = instr_valid && (instr_word[13:3] == xdl_pkg::op_direction_load);
      dir_ok = (instr_word[2:0] >= xdl_pkg::dir_first) && (instr_word[2:0] <= xdl_pkg::dir_last);
      dir_sel = 2'(instr_word[2:0] - xdl_pkg::dir_first);
      file_addr = instr_word[6:0];
      // file operand may itself be a direction register
      dir_hit = (file_addr >= xdl_pkg::dir_file_base) && (file_addr <= 7'(xdl_pkg::dir_file_base + 7'h2));
      dir_rdata = dir_hit ? r.dir[2'(file_addr - xdl_pkg::dir_file_base)] : 8'h00; // RULE6
      file_src = dir_hit ? dir_rdata : file_rdata;
      lit_res = r.acc ^ instr_word[7:0]; // RULE1
      file_res = r.acc ^ file_src; // RULE2
      ext_dir_hit = (file_addr_ext >= xdl_pkg::dir_file_base)
         && (file_addr_ext <= 7'(xdl_pkg::dir_file_base + 7'h2));
      ext_sel = 2'(file_addr_ext - xdl_pkg::dir_file_base);
   end

   // write-back port toward the register file
   always_comb begin
      file_we = is_file && instr_word[7]; // RULE4
      file_wdata = file_res;
   end

   // next-state computation
   always_comb begin
      next_r = r;
      next_r.done = 1'b0;
      next_r.last_op = xdl_pkg::xdl_idle_e;
      if (is_lit) begin
         next_r.acc = lit_res; // RULE1
         next_r.zero = (lit_res == 8'h00);
         next_r.done = 1'b1; // RULE8
         next_r.last_op = xdl_pkg::xdl_lit_e;
      end else if (is_file) begin
         if (!instr_word[7]) begin
            next_r.acc = file_res; // RULE3
         end else if (dir_hit) begin
            next_r.dir[2'(file_addr - xdl_pkg::dir_file_base)] = file_res; // RULE4
         end
         next_r.zero = (file_res == 8'h00); // RULE2
         next_r.done = 1'b1; // RULE8
         next_r.last_op = xdl_pkg::xdl_file_e;
      end else if (is_dir) begin
         if (dir_ok) begin
            next_r.dir[dir_sel] = r.acc; // RULE5
         end
         next_r.done = 1'b1; // RULE8
         next_r.last_op = xdl_pkg::xdl_dir_e;
      end
      // ordinary instructions elsewhere in the core write direction registers
      if (file_we_ext && ext_dir_hit) begin
         next_r.dir[ext_sel] = file_wdata_ext; // RULE6
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         r.acc <= xdl_pkg::acc_reset;
         r.zero <= 1'b0;
         r.dir <= {3{xdl_pkg::dir_reset}};
         r.done <= 1'b0;
         r.last_op <= xdl_pkg::xdl_idle_e;
      end else begin
         r <= next_r;
      end
   end

   // outputs
   always_comb begin
      acc = r.acc;
      zero_flag = r.zero;
      dir_regs = r.dir;
      done = r.done;
   end

   // checks
   property p_lit;
      @(posedge sys_clk) disable iff (srst)
      is_lit |=> (acc == ($past(acc) ^ $past(instr_word[7:0]))) && (zero_flag == (acc == 8'h00));
   endproperty
   a_lit: assert property (p_lit) else $error("literal xor result wrong"); // RULE1

   property p_file_z;
      @(posedge sys_clk) disable iff (srst)
      is_file |=> zero_flag == ($past(file_res) == 8'h00);
   endproperty
   a_file_z: assert property (p_file_z) else $error("file xor zero flag wrong"); // RULE2

   property p_d0;
      @(posedge sys_clk) disable iff (srst)
      (is_file && !instr_word[7]) |-> !file_we ##1 acc == $past(r.acc ^ file_src);
   endproperty
   a_d0: assert property (p_d0) else $error("d=0 destination wrong"); // RULE3

   property p_d1;
      @(posedge sys_clk) disable iff (srst)
      (is_file && instr_word[7]) |-> file_we && file_wdata == (r.acc ^ file_src) ##1 acc == $past(acc);
   endproperty
   a_d1: assert property (p_d1) else $error("d=1 destination wrong"); // RULE4

   property p_dir;
      @(posedge sys_clk) disable iff (srst)
      (is_dir && dir_ok && !file_we_ext) |=> dir_regs[8*$past(dir_sel) +: 8] == $past(acc)
         && $stable(zero_flag) && $stable(acc);
   endproperty
   a_dir: assert property (p_dir) else $error("direction load wrong"); // RULE5

   property p_dir_file;
      @(posedge sys_clk) disable iff (srst)
      (file_we_ext && ext_dir_hit && !is_file && !is_dir) |=> dir_regs[8*$past(ext_sel) +: 8] == $past(file_wdata_ext);
   endproperty
   a_dir_file: assert property (p_dir_file) else $error("direction file write lost"); // RULE6

   property p_one_cycle;
      @(posedge sys_clk) disable iff (srst)
      (is_lit || is_file || is_dir) |=> done;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("instruction not done in one cycle"); // RULE8

   property p_no_spurious;
      @(posedge sys_clk) disable iff (srst)
      !(is_lit || is_file || is_dir) |=> !done && $stable(acc) ##0 $stable(zero_flag);
   endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("state changed with no instruction"); // RULE8

   // a refused operand leaves the direction registers, accumulator and zero flag as they were
   property p_refused;
      @(posedge sys_clk) disable iff (srst)
      (is_dir && !dir_ok && !file_we_ext) |=> $stable(dir_regs) && $stable(acc) && $stable(zero_flag);
   endproperty
   a_refused: assert property (p_refused) else $error("refused direction load changed state"); // RULE5

   // d=0 must not disturb the direction copies
   property p_file_keep;
      @(posedge sys_clk) disable iff (srst)
      (is_file && !instr_word[7] && !file_we_ext) |=> $stable(dir_regs);
   endproperty
   a_file_keep: assert property (p_file_keep) else $error("file xor d=0 touched a direction register"); // RULE3

   // literal xor leaves the direction registers as they were
   property p_lit_keep;
      @(posedge sys_clk) disable iff (srst)
      (is_lit && !file_we_ext) |=> $stable(dir_regs);
   endproperty
   a_lit_keep: assert property (p_lit_keep) else $error("literal xor touched a direction register"); // RULE1

   // the middle direction register reads back through file space
   property p_dir_read;
      @(posedge sys_clk) disable iff (srst)
      (file_addr == 7'(xdl_pkg::dir_file_base + 7'h1)) |-> dir_hit && (dir_rdata == dir_regs[15:8]);
   endproperty
   a_dir_read: assert property (p_dir_read) else $error("direction register not visible in file space"); // RULE6

   // d=1 onto the last direction register stores there, the others hold
   property p_file_d1_dir;
      @(posedge sys_clk) disable iff (srst)
      (is_file && instr_word[7] && (file_addr == 7'(xdl_pkg::dir_file_base + 7'h2)) && !file_we_ext)
         |=> (dir_regs[23:16] == $past(acc ^ dir_regs[23:16])) && (dir_regs[15:0] == $past(dir_regs[15:0]));
   endproperty
   a_file_d1_dir: assert property (p_file_d1_dir) else $error("file xor d=1 lost on direction register"); // RULE4

   // the write strobe belongs to file xor alone
   property p_we_only_file;
      @(posedge sys_clk) disable iff (srst)
      !is_file |-> !file_we;
   endproperty
   a_we_only_file: assert property (p_we_only_file) else $error("stray file write strobe"); // RULE4

   // main scenarios

   c_lit: cover property (@(posedge sys_clk) disable iff (srst) is_lit ##1 zero_flag);
   c_file_d1: cover property (@(posedge sys_clk) disable iff (srst) is_file && instr_word[7]);
   c_dir: cover property (@(posedge sys_clk) disable iff (srst) is_dir && dir_ok);
   c_dir_flag: cover property (@(posedge sys_clk) disable iff (srst) r.last_op == xdl_pkg::xdl_dir_e && zero_flag);
endmodule : xdl_core
`default_nettype wire

// [logic/xdl_pkg.sv]
// Purpose: constants for the xor and direction-load decode/execute block
// Assumes: 14-bit instruction words, 8-bit data path, 7-bit file addresses
// Notes: opcode fields are matched against the top bits of the word
//
// Overview of operation
// (RULE1) literal xor: accumulator xor immediate into accumulator, zero flag updated
// (RULE2) file xor: accumulator xor addressed file register 0..127, zero flag updated
// (RULE3) destination bit clear: result into accumulator, file register untouched
// (RULE4) destination bit set: result into file register, accumulator untouched
// (RULE5) direction load copies accumulator into direction register 5..7, no flags change
// (RULE6) direction registers also sit in file space for ordinary reads and writes
// (RULE7) software should prefer file writes over the legacy direction-load opcode
// (RULE8) each instruction is one word and completes in one instruction cycle
package xdl_pkg;
   localparam int unsigned word_w = 14;
   localparam int unsigned data_w = 8;
   localparam int unsigned addr_w = 7;
   // literal xor: 11 1010 kkkk kkkk
   localparam logic [5:0] op_xor_literal = 6'h3a;
   // file xor: 00 0110 dfff ffff
   localparam logic [5:0] op_xor_file = 6'h06;
   // direction load: 00 0000 0110 0fff
   localparam logic [10:0] op_direction_load = 11'h00c;
   localparam logic [2:0] dir_first = 3'h5;
   localparam logic [2:0] dir_last = 3'h7;
   // file-space addresses of the three direction registers
   localparam logic [6:0] dir_file_base = 7'h45;
   localparam logic [7:0] dir_reset = 8'hff;
   localparam logic [7:0] acc_reset = 8'h00;
   typedef enum logic [1:0] {
      xdl_idle_e = 2'b00,
      xdl_lit_e = 2'b01,
      xdl_file_e = 2'b10,
      xdl_dir_e = 2'b11
   } xdl_op_e;
endpackage : xdl_pkg

// [bench/xdl_file_model.sv]
// Purpose: behavioural register file on the far side of the xor block
// Assumes: 128 bytes, read is combinational at the block's address
// Notes: preset with address xor 0x5a so every location differs
`timescale 1ns/1ps
`default_nettype none
module xdl_file_model (
   input wire logic sys_clk,
   input wire logic [6:0] addr,
   output logic [7:0] rdata,
   input wire logic we,
   input wire logic [7:0] wdata
);
   logic [7:0] mem [0:127];
   // preset contents
   initial begin
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
      end
   end
   // combinational read port
   assign rdata = mem[addr];
   // write-back from the block
   always @(posedge sys_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end
endmodule : xdl_file_model
`default_nettype wire

// [bench/xor_and_direction_load_ops_tb_top.sv]
// Purpose: self-checking bench for the xor and direction-load block
// Assumes: file model preset with address xor 0x5a
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module xor_and_direction_load_ops_tb_top;
   logic sys_clk = 1'b0, srst = 1'b1, instr_valid = 1'b0, file_we_ext = 1'b0;
   logic [13:0] instr_word = 14'h0000;
   logic [6:0] file_addr_ext = 7'h00, file_addr;
   logic [7:0] file_wdata_ext = 8'h00, file_rdata, file_wdata, dir_rdata, acc;
   logic file_we, dir_hit, zero_flag, done;
   logic [23:0] dir_regs;
   int fails = 0, n_compared = 0, cycles = 0;
   // 200 MHz clock
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   xdl_core u_dut (.sys_clk, .srst, .instr_valid, .instr_word, .file_rdata, .file_we_ext, .file_addr_ext,
      .file_wdata_ext, .file_addr, .file_we, .file_wdata, .dir_rdata, .dir_hit, .acc, .zero_flag, .dir_regs, .done);
   xdl_file_model u_mem (.sys_clk(sys_clk), .addr(file_addr), .rdata(file_rdata), .we(file_we), .wdata(file_wdata));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic put(input logic [13:0] w);
      instr_valid = 1'b1;
      instr_word = w;
      #1;
   endtask : put
   task automatic step;
      @(posedge sys_clk);
      #1;
      check(done, 1'b1);
   endtask : step
   // one idle cycle; valid drops only here, never twice in one time step
   task automatic rest;
      instr_valid = 1'b0;
      @(posedge sys_clk);
      #1;
      check(done, 1'b0);
   endtask : rest
   task automatic t_literal;
      check({acc, 7'h00, zero_flag, dir_regs[7:0]}, 24'h0000ff);
      put(14'h3ab5);
      step();
      check(acc, 8'hb5);
      put(14'h3aaf);
      step();
      check({acc, zero_flag}, 9'h034);
      put(14'h3a1a);
      step();
      check({acc, zero_flag}, 9'h001);
      rest();
   endtask : t_literal
   task automatic t_file;
      put(14'h3a3c);
      step();
      put(14'h0620);
      check(file_we, 1'b0);
      step();
      check({acc, zero_flag}, 9'h08c);
      put(14'h06ff);
      check({file_we, file_wdata}, 9'h163);
      check(file_addr, 7'h7f);
      step();
      check({acc, zero_flag, u_mem.mem[127]}, 17'h08c63);
      put(14'h3a1c);
      step();
      put(14'h0600);
      step();
      check({acc, zero_flag}, 9'h001);
      rest();
   endtask : t_file
   task automatic t_dir;
      for (int r = 5; r <= 7; r++) begin
         put(14'h3a00 | 14'(r * 17));
         step();
         put(14'h0060 | 14'(r));
         step();
      end
      check(dir_regs, 24'h443355);
      put(14'h061e);
      step();
      put(14'h0064);
      step();
      put(14'h0065);
      step();
      check({zero_flag, dir_regs}, 25'h1443300);
      rest();
   endtask : t_dir
   task automatic t_map;
      file_we_ext = 1'b1;
      file_addr_ext = 7'h46;
      file_wdata_ext = 8'hc3;
      @(posedge sys_clk);
      #1;
      file_we_ext = 1'b0;
      put(14'h0646);
      check({dir_hit, dir_rdata}, 9'h1c3);
      step();
      check(acc, 8'hc3);
      put(14'h06c7);
      step();
      check({acc, dir_regs}, 32'hc387c300);
   endtask : t_map
   task automatic conclude;
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   // main sequence after 12 reset cycles
   initial begin
      repeat (12) @(posedge sys_clk);
      #1;
      srst = 1'b0;
      t_literal();
      t_file();
      t_dir();
      t_map();
      conclude();
   end
   // hang guard
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fails++;
         conclude();
      end
   end
endmodule : xor_and_direction_load_ops_tb_top
`default_nettype wire
